/* File: dv/cior_pins_model.sv */
// Pads of the four ports with outside parts.
// Assumes the bench gives the level outside parts put on pins the block releases.
`timescale 1ns/1ps
module cior_pins_model (
  input  wire [31:0] out_i,
  input  wire [31:0] oe_n_i,
  input  wire [31:0] ext_i,
  output wire [31:0] pin_o
);
  // Driven bits follow the block, released bits follow the outside part
  assign pin_o = (out_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule

/* File: dv/cior_top_sva.sv */
// Checker for the I/O register block bus, readback and port C pads.
// Assumes bind to cior_top; port C shadow needs reset held two cycles or more.
`timescale 1ns/1ps
module cior_top_sva (
  input wire        clk_i,
  input wire        srst_i,
  input wire [7:0]  io_block_base_i,
  input wire [15:0] bus_addr_i,
  input wire [7:0]  bus_wdata_i,
  input wire        bus_wr_i,
  input wire        bus_rd_i,
  input wire        bus_hit_o,
  input wire [7:0]  bus_rdata_o,
  input wire [7:0]  port_a_pin_oe_n_o,
  input wire [7:0]  port_c_pin_o,
  input wire [7:0]  port_c_pin_oe_n_o,
  input wire [7:0]  port_d_pin_oe_n_o,
  input wire [7:0]  port_a_cell_latch_i,
  input wire        cell_load_ab_o,
  input wire        cell_load_bc_o,
  input wire [7:0]  cell_load_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  reg  [7:0] lat_q;
  reg  [7:0] dir_q;
  reg  [7:0] drv_q;
  wire       wr_hit = bus_wr_i && bus_hit_o;
  wire       rd_hit = bus_rd_i && bus_hit_o;
  wire [7:0] oe_exp = ~(dir_q & ~(drv_q & lat_q));
  // Shadow of port C settings, kept from bus writes alone
  always @(posedge clk_i) begin
    if (srst_i) begin
      lat_q <= 8'h00;
      dir_q <= 8'h00;
      drv_q <= 8'h00;
    end else if (wr_hit) begin
      if (bus_addr_i[7:0] == 8'h12) lat_q <= bus_wdata_i;
      if (bus_addr_i[7:0] == 8'h14) dir_q <= bus_wdata_i;
      if (bus_addr_i[7:0] == 8'h16) drv_q <= bus_wdata_i;
    end
  end
  sequence rd_en_a;
    rd_hit && bus_addr_i[7:0] == 8'h0C;
  endsequence
  sequence rd_en_d;
    rd_hit && bus_addr_i[7:0] == 8'h1B;
  endsequence
  sequence rd_cell_a;
    rd_hit && bus_addr_i[7:0] == 8'h0A;
  endsequence
  sequence wr_cell_ab;
    wr_hit && bus_addr_i[7:0] == 8'h20;
  endsequence
  base_decode_a: assert property (bus_hit_o == (bus_addr_i[15:8] == io_block_base_i))
    else $error("hit does not follow base compare");
  miss_hold_a: assert property (bus_rd_i && !bus_hit_o |=> $stable(bus_rdata_o))
    else $error("read outside block changed read data");
  enable_a_a: assert property (rd_en_a |=> bus_rdata_o == ~$past(port_a_pin_oe_n_o))
    else $error("port A enable readback wrong");
  enable_d_a: assert property (rd_en_d |=> bus_rdata_o == (~$past(port_d_pin_oe_n_o) & 8'h06))
    else $error("port D enable readback wrong");
  cell_read_a: assert property (rd_cell_a |=> bus_rdata_o == $past(port_a_cell_latch_i))
    else $error("input cell readback wrong");
  cell_load_a: assert property (wr_cell_ab |=> cell_load_ab_o && cell_load_data_o == $past(bus_wdata_i))
    else $error("output cell load missing");
  no_load_a: assert property (!(wr_hit && bus_addr_i[7:0] == 8'h20) |=> !cell_load_ab_o)
    else $error("output cell load without write");
  load_bc_a: assert property (cell_load_bc_o == $past(wr_hit && bus_addr_i[7:0] == 8'h21))
    else $error("output cell BC load pulse wrong");
  pad_enable_a: assert property (1'h1 |-> port_c_pin_oe_n_o == $past(oe_exp))
    else $error("port C driver enable wrong");
  pad_data_a: assert property (1'h1 |-> port_c_pin_o == $past(lat_q & ~drv_q))
    else $error("port C pad data wrong");
  reset_clear_a: assert property (@(posedge clk_i) disable iff (1'h0)
    srst_i |=> port_c_pin_oe_n_o == 8'hFF && bus_rdata_o == 8'h00)
    else $error("reset left pads or read data set");
endmodule

bind cior_top cior_top_sva u_sva (
  .clk_i(clk_i), .srst_i(srst_i), .io_block_base_i(io_block_base_i),
  .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i),
  .bus_rd_i(bus_rd_i), .bus_hit_o(bus_hit_o), .bus_rdata_o(bus_rdata_o),
  .port_a_pin_oe_n_o(port_a_pin_oe_n_o), .port_c_pin_o(port_c_pin_o),
  .port_c_pin_oe_n_o(port_c_pin_oe_n_o), .port_d_pin_oe_n_o(port_d_pin_oe_n_o),
  .port_a_cell_latch_i(port_a_cell_latch_i), .cell_load_ab_o(cell_load_ab_o),
  .cell_load_bc_o(cell_load_bc_o),
  .cell_load_data_o(cell_load_data_o)
);

/* File: dv/config_io_register_block_tb.sv */
// Bench for the I/O register block: bus tasks and directed tests.
// Assumes the pins model on all four ports and the bound checker.
`timescale 1ns/1ps
module config_io_register_block_tb;
  localparam [159:0] OFS = {8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h12, 8'h13,
    8'h14, 8'h15, 8'h16, 8'h17, 8'h22, 8'h23, 8'hB0, 8'hB4, 8'hE0, 8'hE2};
  localparam [159:0] MSK = {64'hFFFFFFFFFFFFFFFF, 8'hFF, 8'h06, 8'hFF, 8'h06, 8'hFF, 8'h06,
    8'hFF, 8'hFF, 8'h3A, 8'h3C, 8'hFF, 8'h9F};
  localparam [47:0] CFO = {8'hE2, 8'hE0, 8'hB4, 8'hB0, 8'h23, 8'h22};
  localparam [47:0] CFG = {8'h9F, 8'hC3, 8'h3C, 8'h3A, 8'h69, 8'h96};
  reg         clk_i = 1'h0;
  reg         srst_i = 1'h1;
  reg  [7:0]  base = 8'h7F;
  reg  [15:0] addr = 16'h0000;
  reg  [7:0]  wdata = 8'h00;
  reg         bwr = 1'h0;
  reg         brd = 1'h0;
  reg  [31:0] ext = 32'h00000000;
  reg  [15:0] alt = 16'h00C3;
  reg  [23:0] cl = 24'h000000;
  reg  [15:0] co = 16'h0000;
  reg  [15:0] fl = 16'h0000;
  wire [31:0] po;
  wire [31:0] pe;
  wire [31:0] pins;
  wire [7:0]  rdata;
  wire [47:0] cfg;
  integer     errors = 0;
  integer     n_tests = 0;
  integer     i;
  // 40 MHz
  always #12.5 clk_i = ~clk_i;
  cior_pins_model u_pins (.out_i(po), .oe_n_i(pe), .ext_i(ext), .pin_o(pins));
  cior_top uut (
    .clk_i(clk_i), .srst_i(srst_i), .io_block_base_i(base), .bus_addr_i(addr),
    .bus_wdata_i(wdata), .bus_wr_i(bwr), .bus_rd_i(brd), .bus_hit_o(), .bus_rdata_o(rdata),
    .port_a_pin_i(pins[7:0]), .port_b_pin_i(pins[15:8]), .port_c_pin_i(pins[23:16]),
    .port_d_pin_i(pins[31:24]), .port_a_alt_i(alt[7:0]), .port_b_alt_i(alt[15:8]),
    .port_c_alt_i(8'h00), .port_d_alt_i(8'h00),
    .port_a_pin_o(po[7:0]), .port_b_pin_o(po[15:8]), .port_c_pin_o(po[23:16]),
    .port_d_pin_o(po[31:24]), .port_a_pin_oe_n_o(pe[7:0]), .port_b_pin_oe_n_o(pe[15:8]),
    .port_c_pin_oe_n_o(pe[23:16]), .port_d_pin_oe_n_o(pe[31:24]),
    .port_a_cell_latch_i(cl[7:0]), .port_b_cell_latch_i(cl[15:8]),
    .port_c_cell_latch_i(cl[23:16]), .cell_out_ab_i(co[7:0]), .cell_out_bc_i(co[15:8]),
    .cell_load_ab_o(), .cell_load_bc_o(), .cell_load_data_o(), .cell_mask_ab_o(cfg[7:0]),
    .cell_mask_bc_o(cfg[15:8]), .logic_power_control_o(cfg[23:16]),
    .logic_input_blocking_o(cfg[31:24]), .main_flash_lock_i(fl[7:0]),
    .second_flash_lock_i(fl[15:8]), .page_o(cfg[39:32]), .space_mapping_o(cfg[47:40])
  );
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Strobe rises on an edge and drops on the taking edge
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      bwr <= 1'h1;
      @(posedge clk_i);
      bwr <= 1'h0;
    end
  endtask
  // Read data lands on the taking edge; looked at just after it
  task rd(input [15:0] a, input [7:0] e);
    begin
      @(posedge clk_i);
      addr <= a;
      brd <= 1'h1;
      @(posedge clk_i);
      brd <= 1'h0;
      #1 chk(rdata, e);
    end
  endtask
  // Pads are registered off the latch, one edge behind it
  task wait2;
    begin
      repeat (2) @(posedge clk_i);
      #1;
    end
  endtask
  task tdone(input [8*8-1:0] s);
    $display("test %0s done", s);
  endtask
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // Watchdog, over twenty times the expected run
  initial begin
    #200000;
    errors = errors + 1;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'h0;
    for (i = 0; i < 20; i = i + 1)
      rd({base, OFS[8*i +: 8]}, 8'h00);
    rd({base, 8'h1A}, 8'h00);
    chk(pe[23:16], 8'hFF);
    tdone("reset");
    // Unused bits store nothing, an RO place ignores writes, an unmapped place reads zero
    for (i = 0; i < 20; i = i + 1) begin
      wr({base, OFS[8*i +: 8]}, 8'hFF);
      rd({base, OFS[8*i +: 8]}, MSK[8*i +: 8]);
      wr({base, OFS[8*i +: 8]}, 8'h00);
      rd({base, OFS[8*i +: 8]}, 8'h00);
    end
    // Outputs toward the logic and memory follow the bus writes
    for (i = 0; i < 6; i = i + 1)
      wr({base, CFO[8*i +: 8]}, CFG[8*i +: 8]);
    #1;
    for (i = 0; i < 6; i = i + 1)
      chk(cfg[8*i +: 8], CFG[8*i +: 8]);
    wr({base, 8'h0C}, 8'hFF);
    rd({base, 8'h0C}, 8'h00);
    rd({base, 8'h30}, 8'h00);
    tdone("masks");
    // Port C push-pull then open drain, outside part on the released pins
    @(posedge clk_i);
    ext <= 32'h003C0000;
    wr({base, 8'h14}, 8'h0F);
    wr({base, 8'h12}, 8'hA5);
    wait2;
    chk(po[23:16], 8'hA5);
    chk(pe[23:16], 8'hF0);
    rd({base, 8'h1A}, 8'h0F);
    rd({base, 8'h10}, 8'h35);
    wr({base, 8'h16}, 8'hFF);
    wait2;
    chk(po[23:16], 8'h00);
    chk(pe[23:16], 8'hF5);
    rd({base, 8'h1A}, 8'h0A);
    rd({base, 8'h10}, 8'h34);
    // Port A address-out mode, then back to plain I/O
    wr({base, 8'h02}, 8'hFF);
    wr({base, 8'h06}, 8'hFF);
    wait2;
    chk(po[7:0], 8'hC3);
    rd({base, 8'h0C}, 8'hFF);
    wr({base, 8'h02}, 8'h00);
    wr({base, 8'h04}, 8'h5A);
    wait2;
    chk(po[7:0], 8'h5A);
    wr({base, 8'h15}, 8'hFF);
    wr({base, 8'h13}, 8'hFF);
    rd({base, 8'h1B}, 8'h06);
    rd({base, 8'h11}, 8'h06);
    tdone("ports");
    @(posedge clk_i);
    ext[15:8] <= 8'h5A;
    cl <= 24'h1E2D96;
    co <= 16'h3CC3;
    fl <= 16'hFFC3;
    rd({base, 8'h01}, 8'h5A);
    rd({base, 8'h0A}, 8'h96);
    rd({base, 8'h0A}, 8'h96);
    rd({base, 8'h0B}, 8'h2D);
    rd({base, 8'h18}, 8'h1E);
    rd({base, 8'h20}, 8'hC3);
    rd({base, 8'h21}, 8'h3C);
    rd({base, 8'hC0}, 8'hC3);
    rd({base, 8'hC2}, 8'h8F);
    wr({base, 8'h20}, 8'h77);
    rd({base, 8'h20}, 8'hC3);
    wr({base, 8'h21}, 8'h99);
    rd({base, 8'h21}, 8'h3C);
    tdone("cells");
    // Write and read outside the base page are not taken
    wr(16'h4012, 8'hFF);
    rd({base, 8'h12}, 8'hA5);
    @(posedge clk_i);
    base <= 8'hA0;
    rd(16'hA012, 8'hA5);
    rd(16'h7F0A, 8'hA5);
    tdone("decode");
    // Reset in mid-run clears pads and settings
    @(posedge clk_i);
    srst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'h0;
    #1 chk(pe[23:16], 8'hFF);
    chk(po[7:0], 8'h00);
    for (i = 0; i < 6; i = i + 1)
      chk(cfg[8*i +: 8], 8'h00);
    rd({base, 8'h14}, 8'h00);
    tdone("rerun");
    end_sim;
  end
endmodule

/* File: logic/cior_byte_reg.v */
// One writable byte register with a mask of implemented bits.
// Assumes a synchronous write strobe that is high for one cycle per write.
`timescale 1ns/1ps
`include "cior_map.vh"

module cior_byte_reg #(
  parameter [7:0] MASK = 8'hFF,
  parameter [7:0] RST  = 8'h00
) (
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire       we_i,
  input  wire [7:0] d_i,
  output wire [7:0] q_o
);

  reg [7:0] val_q;

  // Unused bits never store, so a stray one from software cannot leak out
  always @(posedge clk_i) begin
    if (srst_i) begin
      val_q <= RST & MASK;
    end else if (we_i) begin
      val_q <= d_i & MASK;
    end
  end

  assign q_o = val_q;

endmodule

/* File: logic/cior_map.vh */
// Register offsets, field masks and reset values of the configuration and I/O block.
// Assumes a byte-wide processor bus. The block sits in one 256-byte page above a base address.
`ifndef CIOR_MAP_VH
`define CIOR_MAP_VH

// Offsets within the block's page
`define CIOR_OFS_A_PIN_IN      8'h00
`define CIOR_OFS_B_PIN_IN      8'h01
`define CIOR_OFS_A_FUNC_SEL    8'h02
`define CIOR_OFS_B_FUNC_SEL    8'h03
`define CIOR_OFS_A_OUT_LATCH   8'h04
`define CIOR_OFS_B_OUT_LATCH   8'h05
`define CIOR_OFS_A_DIRECTION   8'h06
`define CIOR_OFS_B_DIRECTION   8'h07
`define CIOR_OFS_A_DRV_TYPE    8'h08
`define CIOR_OFS_B_DRV_TYPE    8'h09
`define CIOR_OFS_A_CELL_LATCH  8'h0A
`define CIOR_OFS_B_CELL_LATCH  8'h0B
`define CIOR_OFS_A_EN_STATE    8'h0C
`define CIOR_OFS_B_EN_STATE    8'h0D
`define CIOR_OFS_C_PIN_IN      8'h10
`define CIOR_OFS_D_PIN_IN      8'h11
`define CIOR_OFS_C_OUT_LATCH   8'h12
`define CIOR_OFS_D_OUT_LATCH   8'h13
`define CIOR_OFS_C_DIRECTION   8'h14
`define CIOR_OFS_D_DIRECTION   8'h15
`define CIOR_OFS_C_DRV_TYPE    8'h16
`define CIOR_OFS_D_DRV_TYPE    8'h17
`define CIOR_OFS_C_CELL_LATCH  8'h18
`define CIOR_OFS_C_EN_STATE    8'h1A
`define CIOR_OFS_D_EN_STATE    8'h1B
`define CIOR_OFS_CELL_OUT_AB   8'h20
`define CIOR_OFS_CELL_OUT_BC   8'h21
`define CIOR_OFS_CELL_MASK_AB  8'h22
`define CIOR_OFS_CELL_MASK_BC  8'h23
`define CIOR_OFS_POWER_CTL     8'hB0
`define CIOR_OFS_INPUT_BLOCK   8'hB4
`define CIOR_OFS_MAIN_LOCK     8'hC0
`define CIOR_OFS_SECOND_LOCK   8'hC2
`define CIOR_OFS_PAGE          8'hE0
`define CIOR_OFS_SPACE_MAP     8'hE2

// Bits in use per register; the rest store nothing and read as zero
`define CIOR_MASK_FULL         8'hFF
`define CIOR_MASK_PORT_D       8'h06
`define CIOR_MASK_POWER_CTL    8'h3A
`define CIOR_MASK_INPUT_BLOCK  8'h3C
`define CIOR_MASK_SECOND_LOCK  8'h8F
`define CIOR_MASK_SPACE_MAP    8'h9F

// Reset values
`define CIOR_RST_ZERO          8'h00
`define CIOR_RST_SPACE_MAP     8'h00
`define CIOR_RD_IDLE           8'h00

`endif

/* File: logic/cior_port.v */
// One general-purpose port: function select, output latch, direction and drive type.
// Assumes pins are sampled in the clock domain and resolved by the surrounding pad ring.
`timescale 1ns/1ps
`include "cior_map.vh"

module cior_port #(
  parameter [7:0] MASK = 8'hFF
) (
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_func_i,
  input  wire       wr_out_i,
  input  wire       wr_dir_i,
  input  wire       wr_drv_i,
  input  wire [7:0] alt_out_i,
  output wire [7:0] out_latch_o,
  output wire [7:0] direction_o,
  output wire [7:0] drv_type_o,
  output wire [7:0] func_sel_o,
  output reg  [7:0] pin_out_o,
  output reg  [7:0] pin_oe_n_o,
  output wire [7:0] en_state_o
);

  reg  [7:0] out_d;
  reg  [7:0] en_d;

  cior_byte_reg #(.MASK(MASK), .RST(`CIOR_RST_ZERO)) u_func (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .we_i   (wr_func_i),
    .d_i    (wdata_i),
    .q_o    (func_sel_o)
  );

  cior_byte_reg #(.MASK(MASK), .RST(`CIOR_RST_ZERO)) u_out (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .we_i   (wr_out_i),
    .d_i    (wdata_i),
    .q_o    (out_latch_o)
  );

  cior_byte_reg #(.MASK(MASK), .RST(`CIOR_RST_ZERO)) u_dir (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .we_i   (wr_dir_i),
    .d_i    (wdata_i),
    .q_o    (direction_o)
  );

  cior_byte_reg #(.MASK(MASK), .RST(`CIOR_RST_ZERO)) u_drv (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .we_i   (wr_drv_i),
    .d_i    (wdata_i),
    .q_o    (drv_type_o)
  );

  // Pin source and enable; open drain only pulls low, so a one floats the pin
  always @* begin
    out_d = (func_sel_o & alt_out_i) | (~func_sel_o & out_latch_o);
    en_d  = direction_o & MASK & ~(drv_type_o & out_d);
  end

  // Registered pad controls keep glitches off the pins
  always @(posedge clk_i) begin
    if (srst_i) begin
      pin_out_o  <= `CIOR_RST_ZERO;
      pin_oe_n_o <= ~`CIOR_RST_ZERO;
    end else begin
      pin_out_o  <= out_d & ~(drv_type_o & out_d);
      pin_oe_n_o <= ~en_d;
    end
  end

  assign en_state_o = ~pin_oe_n_o & MASK;

endmodule

/* File: logic/cior_top.v */
// Configuration and I/O register block: four ports, logic-cell access and memory control.
// Assumes a synchronous byte bus; reads answer one cycle after the read strobe.
`timescale 1ns/1ps
`include "cior_map.vh"

// How it works
// - Written output latch drives pins set as outputs in plain I/O mode.
// - Reading input cell latch returns the captured value and leaves it unchanged.
// - Enable readback shows each pin driver's present output-enable state.
// - Enable readback bit zero means driver off and pin acting as input.
// - Registers decode at user base address plus fixed offset.
module cior_top (
  // Clock, reset and block base
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire [7:0]  io_block_base_i,
  // Processor register bus
  input  wire [15:0] bus_addr_i,
  input  wire [7:0]  bus_wdata_i,
  input  wire        bus_wr_i,
  input  wire        bus_rd_i,
  output wire        bus_hit_o,
  output reg  [7:0]  bus_rdata_o,
  // Port pins and alternate sources
  input  wire [7:0]  port_a_pin_i,
  input  wire [7:0]  port_b_pin_i,
  input  wire [7:0]  port_c_pin_i,
  input  wire [7:0]  port_d_pin_i,
  input  wire [7:0]  port_a_alt_i,
  input  wire [7:0]  port_b_alt_i,
  input  wire [7:0]  port_c_alt_i,
  input  wire [7:0]  port_d_alt_i,
  output wire [7:0]  port_a_pin_o,
  output wire [7:0]  port_b_pin_o,
  output wire [7:0]  port_c_pin_o,
  output wire [7:0]  port_d_pin_o,
  output wire [7:0]  port_a_pin_oe_n_o,
  output wire [7:0]  port_b_pin_oe_n_o,
  output wire [7:0]  port_c_pin_oe_n_o,
  output wire [7:0]  port_d_pin_oe_n_o,
  // Programmable logic cells
  input  wire [7:0]  port_a_cell_latch_i,
  input  wire [7:0]  port_b_cell_latch_i,
  input  wire [7:0]  port_c_cell_latch_i,
  input  wire [7:0]  cell_out_ab_i,
  input  wire [7:0]  cell_out_bc_i,
  output reg         cell_load_ab_o,
  output reg         cell_load_bc_o,
  output reg  [7:0]  cell_load_data_o,
  output wire [7:0]  cell_mask_ab_o,
  output wire [7:0]  cell_mask_bc_o,
  output wire [7:0]  logic_power_control_o,
  output wire [7:0]  logic_input_blocking_o,
  // Flash protection and memory control
  input  wire [7:0]  main_flash_lock_i,
  input  wire [7:0]  second_flash_lock_i,
  output wire [7:0]  page_o,
  output wire [7:0]  space_mapping_o
);

  // Address decode and read path
  wire [7:0] ofs;
  wire       wr_hit;
  wire       rd_hit;
  reg  [7:0] rd_d;

  // One write strobe per writable register or cell load
  wire       wr_a_func;
  wire       wr_a_out;
  wire       wr_a_dir;
  wire       wr_a_drv;
  wire       wr_b_func;
  wire       wr_b_out;
  wire       wr_b_dir;
  wire       wr_b_drv;
  wire       wr_c_out;
  wire       wr_c_dir;
  wire       wr_c_drv;
  wire       wr_d_out;
  wire       wr_d_dir;
  wire       wr_d_drv;
  wire       wr_mask_ab;
  wire       wr_mask_bc;
  wire       wr_power;
  wire       wr_block;
  wire       wr_page;
  wire       wr_space;
  wire       wr_cell_ab;
  wire       wr_cell_bc;

  // Port A register values
  wire [7:0] a_out;
  wire [7:0] a_dir;
  wire [7:0] a_drv;
  wire [7:0] a_func;
  wire [7:0] a_en;

  // Port B register values
  wire [7:0] b_out;
  wire [7:0] b_dir;
  wire [7:0] b_drv;
  wire [7:0] b_func;
  wire [7:0] b_en;

  // Port C register values; no function select here
  wire [7:0] c_out;
  wire [7:0] c_dir;
  wire [7:0] c_drv;
  wire [7:0] c_en;

  // Port D register values; only two pins carry anything
  wire [7:0] d_out;
  wire [7:0] d_dir;
  wire [7:0] d_drv;
  wire [7:0] d_en;

  // Page decode: the whole block lives in the 256 bytes above the base
  assign bus_hit_o = (bus_addr_i[15:8] == io_block_base_i);
  assign ofs       = bus_addr_i[7:0];
  assign wr_hit    = bus_wr_i & bus_hit_o;
  assign rd_hit    = bus_rd_i & bus_hit_o;

  // Register strobes, one offset compare each; misses never reach a register
  assign wr_a_func  = wr_hit & (ofs == `CIOR_OFS_A_FUNC_SEL);
  assign wr_a_out   = wr_hit & (ofs == `CIOR_OFS_A_OUT_LATCH);
  assign wr_a_dir   = wr_hit & (ofs == `CIOR_OFS_A_DIRECTION);
  assign wr_a_drv   = wr_hit & (ofs == `CIOR_OFS_A_DRV_TYPE);
  assign wr_b_func  = wr_hit & (ofs == `CIOR_OFS_B_FUNC_SEL);
  assign wr_b_out   = wr_hit & (ofs == `CIOR_OFS_B_OUT_LATCH);
  assign wr_b_dir   = wr_hit & (ofs == `CIOR_OFS_B_DIRECTION);
  assign wr_b_drv   = wr_hit & (ofs == `CIOR_OFS_B_DRV_TYPE);
  assign wr_c_out   = wr_hit & (ofs == `CIOR_OFS_C_OUT_LATCH);
  assign wr_c_dir   = wr_hit & (ofs == `CIOR_OFS_C_DIRECTION);
  assign wr_c_drv   = wr_hit & (ofs == `CIOR_OFS_C_DRV_TYPE);
  assign wr_d_out   = wr_hit & (ofs == `CIOR_OFS_D_OUT_LATCH);
  assign wr_d_dir   = wr_hit & (ofs == `CIOR_OFS_D_DIRECTION);
  assign wr_d_drv   = wr_hit & (ofs == `CIOR_OFS_D_DRV_TYPE);
  assign wr_mask_ab = wr_hit & (ofs == `CIOR_OFS_CELL_MASK_AB);
  assign wr_mask_bc = wr_hit & (ofs == `CIOR_OFS_CELL_MASK_BC);
  assign wr_power   = wr_hit & (ofs == `CIOR_OFS_POWER_CTL);
  assign wr_block   = wr_hit & (ofs == `CIOR_OFS_INPUT_BLOCK);
  assign wr_page    = wr_hit & (ofs == `CIOR_OFS_PAGE);
  assign wr_space   = wr_hit & (ofs == `CIOR_OFS_SPACE_MAP);
  assign wr_cell_ab = wr_hit & (ofs == `CIOR_OFS_CELL_OUT_AB);
  assign wr_cell_bc = wr_hit & (ofs == `CIOR_OFS_CELL_OUT_BC);

  // Port A, full width
  cior_port #(.MASK(`CIOR_MASK_FULL)) u_port_a (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .wdata_i     (bus_wdata_i),
    .wr_func_i   (wr_a_func),
    .wr_out_i    (wr_a_out),
    .wr_dir_i    (wr_a_dir),
    .wr_drv_i    (wr_a_drv),
    .alt_out_i   (port_a_alt_i),
    .out_latch_o (a_out),
    .direction_o (a_dir),
    .drv_type_o  (a_drv),
    .func_sel_o  (a_func),
    .pin_out_o   (port_a_pin_o),
    .pin_oe_n_o  (port_a_pin_oe_n_o),
    .en_state_o  (a_en)
  );

  // Port B, full width
  cior_port #(.MASK(`CIOR_MASK_FULL)) u_port_b (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .wdata_i     (bus_wdata_i),
    .wr_func_i   (wr_b_func),
    .wr_out_i    (wr_b_out),
    .wr_dir_i    (wr_b_dir),
    .wr_drv_i    (wr_b_drv),
    .alt_out_i   (port_b_alt_i),
    .out_latch_o (b_out),
    .direction_o (b_dir),
    .drv_type_o  (b_drv),
    .func_sel_o  (b_func),
    .pin_out_o   (port_b_pin_o),
    .pin_oe_n_o  (port_b_pin_oe_n_o),
    .en_state_o  (b_en)
  );

  // Port C has no function select register, so it stays in plain I/O mode
  cior_port #(.MASK(`CIOR_MASK_FULL)) u_port_c (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .wdata_i     (bus_wdata_i),
    .wr_func_i   (1'b0),
    .wr_out_i    (wr_c_out),
    .wr_dir_i    (wr_c_dir),
    .wr_drv_i    (wr_c_drv),
    .alt_out_i   (port_c_alt_i),
    .out_latch_o (c_out),
    .direction_o (c_dir),
    .drv_type_o  (c_drv),
    .func_sel_o  (),
    .pin_out_o   (port_c_pin_o),
    .pin_oe_n_o  (port_c_pin_oe_n_o),
    .en_state_o  (c_en)
  );

  // Port D implements two pins only; the mask keeps the rest inert
  cior_port #(.MASK(`CIOR_MASK_PORT_D)) u_port_d (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .wdata_i     (bus_wdata_i),
    .wr_func_i   (1'b0),
    .wr_out_i    (wr_d_out),
    .wr_dir_i    (wr_d_dir),
    .wr_drv_i    (wr_d_drv),
    .alt_out_i   (port_d_alt_i),
    .out_latch_o (d_out),
    .direction_o (d_dir),
    .drv_type_o  (d_drv),
    .func_sel_o  (),
    .pin_out_o   (port_d_pin_o),
    .pin_oe_n_o  (port_d_pin_oe_n_o),
    .en_state_o  (d_en)
  );

  // Logic-cell masks
  cior_byte_reg #(.MASK(`CIOR_MASK_FULL), .RST(`CIOR_RST_ZERO)) u_mask_ab (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .we_i   (wr_mask_ab),
    .d_i    (bus_wdata_i),
    .q_o    (cell_mask_ab_o)
  );

  cior_byte_reg #(.MASK(`CIOR_MASK_FULL), .RST(`CIOR_RST_ZERO)) u_mask_bc (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .we_i   (wr_mask_bc),
    .d_i    (bus_wdata_i),
    .q_o    (cell_mask_bc_o)
  );

  // Programmable-logic power and input blocking
  cior_byte_reg #(.MASK(`CIOR_MASK_POWER_CTL), .RST(`CIOR_RST_ZERO)) u_power (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .we_i   (wr_power),
    .d_i    (bus_wdata_i),
    .q_o    (logic_power_control_o)
  );

  cior_byte_reg #(.MASK(`CIOR_MASK_INPUT_BLOCK), .RST(`CIOR_RST_ZERO)) u_block (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .we_i   (wr_block),
    .d_i    (bus_wdata_i),
    .q_o    (logic_input_blocking_o)
  );

  // Memory page and program/data space mapping
  cior_byte_reg #(.MASK(`CIOR_MASK_FULL), .RST(`CIOR_RST_ZERO)) u_page (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .we_i   (wr_page),
    .d_i    (bus_wdata_i),
    .q_o    (page_o)
  );

  cior_byte_reg #(.MASK(`CIOR_MASK_SPACE_MAP), .RST(`CIOR_RST_SPACE_MAP)) u_space (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .we_i   (wr_space),
    .d_i    (bus_wdata_i),
    .q_o    (space_mapping_o)
  );

  // Writes to the output cells are forwarded as a load pulse; the cells own the value
  always @(posedge clk_i) begin
    if (srst_i) begin
      cell_load_ab_o   <= 1'b0;
      cell_load_bc_o   <= 1'b0;
      cell_load_data_o <= `CIOR_RST_ZERO;
    end else begin
      cell_load_ab_o <= wr_cell_ab;
      cell_load_bc_o <= wr_cell_bc;
      // Data follows any hit write; the pulse tells the cells which one took it
      if (wr_hit) begin
        cell_load_data_o <= bus_wdata_i;
      end
    end
  end

  // Read multiplexer; unmapped offsets answer zero
  always @* begin
    case (ofs)
      // Ports A and B
      `CIOR_OFS_A_PIN_IN:     rd_d = port_a_pin_i;
      `CIOR_OFS_B_PIN_IN:     rd_d = port_b_pin_i;
      `CIOR_OFS_A_FUNC_SEL:   rd_d = a_func;
      `CIOR_OFS_B_FUNC_SEL:   rd_d = b_func;
      `CIOR_OFS_A_OUT_LATCH:  rd_d = a_out;
      `CIOR_OFS_B_OUT_LATCH:  rd_d = b_out;
      `CIOR_OFS_A_DIRECTION:  rd_d = a_dir;
      `CIOR_OFS_B_DIRECTION:  rd_d = b_dir;
      `CIOR_OFS_A_DRV_TYPE:   rd_d = a_drv;
      `CIOR_OFS_B_DRV_TYPE:   rd_d = b_drv;
      `CIOR_OFS_A_CELL_LATCH: rd_d = port_a_cell_latch_i;
      `CIOR_OFS_B_CELL_LATCH: rd_d = port_b_cell_latch_i;
      `CIOR_OFS_A_EN_STATE:   rd_d = a_en;
      `CIOR_OFS_B_EN_STATE:   rd_d = b_en;
      // Ports C and D
      `CIOR_OFS_C_PIN_IN:     rd_d = port_c_pin_i;
      `CIOR_OFS_D_PIN_IN:     rd_d = port_d_pin_i & `CIOR_MASK_PORT_D;
      `CIOR_OFS_C_OUT_LATCH:  rd_d = c_out;
      `CIOR_OFS_D_OUT_LATCH:  rd_d = d_out;
      `CIOR_OFS_C_DIRECTION:  rd_d = c_dir;
      `CIOR_OFS_D_DIRECTION:  rd_d = d_dir;
      `CIOR_OFS_C_DRV_TYPE:   rd_d = c_drv;
      `CIOR_OFS_D_DRV_TYPE:   rd_d = d_drv;
      `CIOR_OFS_C_CELL_LATCH: rd_d = port_c_cell_latch_i;
      `CIOR_OFS_C_EN_STATE:   rd_d = c_en;
      `CIOR_OFS_D_EN_STATE:   rd_d = d_en;
      // Logic cells, flash protection and memory control
      `CIOR_OFS_CELL_OUT_AB:  rd_d = cell_out_ab_i;
      `CIOR_OFS_CELL_OUT_BC:  rd_d = cell_out_bc_i;
      `CIOR_OFS_CELL_MASK_AB: rd_d = cell_mask_ab_o;
      `CIOR_OFS_CELL_MASK_BC: rd_d = cell_mask_bc_o;
      `CIOR_OFS_POWER_CTL:    rd_d = logic_power_control_o;
      `CIOR_OFS_INPUT_BLOCK:  rd_d = logic_input_blocking_o;
      `CIOR_OFS_MAIN_LOCK:    rd_d = main_flash_lock_i;
      `CIOR_OFS_SECOND_LOCK:  rd_d = second_flash_lock_i & `CIOR_MASK_SECOND_LOCK;
      `CIOR_OFS_PAGE:         rd_d = page_o;
      `CIOR_OFS_SPACE_MAP:    rd_d = space_mapping_o;
      default:                rd_d = `CIOR_RD_IDLE;
    endcase
  end

  // Read data is registered; it holds until the next read inside the block so slow masters can sample it
  always @(posedge clk_i) begin
    if (srst_i) begin
      bus_rdata_o <= `CIOR_RD_IDLE;
    end else if (rd_hit) begin
      bus_rdata_o <= rd_d;
    end
  end

endmodule
